// File: dma_pkg.sv
// shared types and cycle constants for the shared-resource dma sequencer
`default_nettype none
package dma_pkg;
  localparam int NCH = 4;                       // channels, 0 is highest priority

  // what the memory port carries for a channel
  typedef enum logic [1:0] {
    MODE_READ   = 2'h0,                         // port is source only
    MODE_WRITE  = 2'h1,                         // port is destination only
    MODE_SHARED = 2'h2                          // port is source and destination
  } mode_t;

  // memory type behind the port
  typedef enum logic [1:0] {
    MEM_INTERNAL = 2'h0,
    MEM_SYNC_BURST = 2'h1,
    MEM_DYNAMIC = 2'h2,
    MEM_ASYNC = 2'h3
  } mem_t;

  // sequencer states, one-hot
  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_LEAD   = 7'h02,
    S_SETUP  = 7'h04,
    S_STROBE = 7'h08,
    S_HOLD   = 7'h10,
    S_TURN   = 7'h20,
    S_GAP    = 7'h40
  } state_t;

  // cycle counts of core_output_clock
  localparam logic [5:0] RSYNC_TO_READ_CYC = 6'h0B; // flag set to first access
  localparam logic [5:0] CE_SETUP_CYC      = 6'h04; // access start to first read data
  localparam logic [5:0] CE_HOLD_CYC       = 6'h04; // last strobe to access end
  localparam logic [5:0] FRAME_GAP_CYC     = 6'h04; // idle between frame bursts
  localparam logic [5:0] ELEM_EXT_CYC      = 6'h02; // external element period
  localparam logic [5:0] ELEM_INT_CYC      = 6'h01; // internal element period
  localparam logic [5:0] SW_RD_WR_CYC      = 6'h06; // read to write switching
  localparam logic [5:0] SW_WR_RD_CYC      = 6'h04; // write to read switching
  localparam logic [5:0] EXTRA_RD_WR_CYC   = 6'h04; // shared-resource extra, read to write
  localparam logic [5:0] EXTRA_WR_RD_CYC   = 6'h04; // shared-resource extra, write to read
  localparam logic [5:0] INT_RD_WR_CYC     = 6'h08; // internal read burst to write burst
  localparam logic [5:0] INT_WR_RD_CYC     = 6'h09; // internal write burst to read burst
  localparam logic [5:0] HP_RD_LP_WR_CYC   = 6'h0F; // extra when lower channel writes after read
  localparam logic [5:0] BURST_FAST        = 6'h05; // internal or synchronous burst read
  localparam logic [5:0] BURST_DYNAMIC     = 6'h06; // dynamic memory read
  localparam logic [5:0] BURST_ASYNC       = 6'h24; // asynchronous memory read
endpackage : dma_pkg
`default_nettype wire

// File: dma_arb_if.sv
// request and grant lines between the sequencer and its channel arbiter
`timescale 1ns/1ps
`default_nettype none
interface dma_arb_if;
  logic [3:0] read_req;                         // channels wanting a read burst
  logic [3:0] write_req;                        // channels wanting a write burst
  logic [3:0] grant;                            // one-hot winner
  modport arbiter (input read_req, input write_req, output grant);
  modport requester (output read_req, output write_req, input grant);
endinterface : dma_arb_if
`default_nettype wire

// File: dma_arbiter.sv
// fixed-priority channel arbiter, writes ahead of reads
`timescale 1ns/1ps
`default_nettype none
module dma_arbiter (
  input  wire logic         clock,
  input  wire logic         nrst,
  dma_arb_if.arbiter        arb
);
  logic [3:0] pool;                             // request class that competes

  // writes win as a class, then the lowest-numbered channel wins
  always_comb begin
    pool = (|arb.write_req) ? arb.write_req : arb.read_req;
    arb.grant = pool & 4'(~pool + 4'h1);
  end

  chk_write_first: assert property (@(posedge clock) disable iff (!nrst)
    (|arb.write_req && |arb.grant) |-> |(arb.grant & arb.write_req))
    else $error("read granted over a pending write");

  chk_lowest_wins: assert property (@(posedge clock) disable iff (!nrst)
    |arb.grant |-> ((4'(arb.grant - 4'h1) & pool) == 4'h0))
    else $error("a lower-numbered request was passed over");
endmodule : dma_arbiter
`default_nettype wire

// File: dma_shared_seq.sv
// dma memory-port sequencer: channel arbitration, bursts, turnarounds and gaps
// Notes on behaviour
// - never read and write port together
// - pending writes granted ahead of reads
// - keep writing while holding registers hold data
// - shared read burst 5, dynamic 6, asynchronous 36
// - external shared turnarounds add extra cycles
// - internal turnaround 8 read-write, 9 write-read
// - sync flag sets one cycle after start
// - first access 11 cycles after flag
// - four idle cycles between frame bursts
// - four cycles from access start to data (external reads only; internal reads and all writes strobe in the first cycle)
// - chip enable ends 4 after read strobe (external memory only; internal ends 1 after)
// - chip enable ends 4 after write strobe (external memory only; internal ends 1 after)
// - read to write switching is 6 cycles
// - lower channel write after read adds 15
// - later lower channel waits for running transfer
// - every frame is its own burst
// - lowest-numbered channel of the winning class wins while the port is idle
// - waiting requests held until port frees
`timescale 1ns/1ps
`default_nettype none
module dma_shared_seq (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire logic [3:0]           start,
  input  wire dma_pkg::mode_t [3:0] chan_mode,
  input  wire dma_pkg::mem_t  [3:0] chan_mem,
  input  wire logic [3:0][7:0]      frame_count,
  input  wire logic [3:0][7:0]      elem_count,
  output logic [3:0]                read_sync_pending_flag,
  output logic [3:0]                chan_done,
  output logic                      busy,
  output logic [1:0]                active_chan,
  output logic                      mem_ce,
  output logic                      mem_write,
  output logic                      rd_strobe,
  output logic                      wr_strobe
);
  // the whole state of the sequencer
  typedef struct packed {
    dma_pkg::state_t state;
    logic [5:0]      cnt;        // cycles left in the current state
    logic [1:0]      chan;       // channel owning the port
    dma_pkg::mode_t  mode;
    dma_pkg::mem_t   mem;
    logic [7:0]      frames;     // frames left including this one
    logic [7:0]      elems;      // elements still to read (or write) in frame
    logic [7:0]      elems_init; // reload value per frame
    logic [5:0]      held;       // elements read but not yet written
    logic [5:0]      in_burst;   // elements moved in current burst
    logic            wr;         // current burst direction
    logic [3:0]      pend;       // started channels not yet finished
    logic [3:0]      flag;       // read-sync pending flags
    logic [3:0]      done;
    logic            last_valid; // a transfer just ended, switching applies
    logic            last_wr;
    logic [1:0]      last_chan;
    logic            ce;
    logic            rd_stb;
    logic            wr_stb;
  } seq_t;

  seq_t       cur;                              // registered state
  seq_t       next_cur;                         // next state
  logic [3:0] wr_only;                          // channel uses port as destination only
  logic [1:0] gidx;                             // granted channel index
  logic [5:0] wait_cyc;                         // switching wait for a new channel
  logic       fin;                              // an access has just ended
  logic       go;                               // an access begins next cycle

  dma_arb_if arb ();

  dma_arbiter u_arb (
    .clock (clock),
    .nrst  (nrst),
    .arb   (arb)
  );

  // elements gathered per shared read burst depend on read memory only
  function automatic logic [5:0] burst_size(input dma_pkg::mem_t m);
    unique case (m)
      dma_pkg::MEM_DYNAMIC: burst_size = dma_pkg::BURST_DYNAMIC;
      dma_pkg::MEM_ASYNC:   burst_size = dma_pkg::BURST_ASYNC;
      default:              burst_size = dma_pkg::BURST_FAST;
    endcase
  endfunction : burst_size

  // one element period on the port
  function automatic logic [5:0] elem_cyc(input dma_pkg::mem_t m);
    elem_cyc = (m == dma_pkg::MEM_INTERNAL) ? dma_pkg::ELEM_INT_CYC : dma_pkg::ELEM_EXT_CYC;
  endfunction : elem_cyc

  // one-hot grant to index
  function automatic logic [1:0] onehot_idx(input logic [3:0] g);
    onehot_idx = g[1] ? 2'h1 : g[2] ? 2'h2 : g[3] ? 2'h3 : 2'h0;
  endfunction : onehot_idx

  // requests are only offered when the port is free, so a running transfer is never cut
  always_comb begin
    for (int i = 0; i < dma_pkg::NCH; i++) begin
      wr_only[i] = (chan_mode[i] == dma_pkg::MODE_WRITE);
    end
    arb.write_req = (cur.state == dma_pkg::S_IDLE) ? (cur.pend & wr_only) : 4'h0;
    arb.read_req  = (cur.state == dma_pkg::S_IDLE) ? (cur.pend & ~wr_only) : 4'h0;
  end

  // next-state logic
  always_comb begin
    next_cur = cur;
    next_cur.done = 4'h0;
    fin = 1'b0;
    go = 1'b0;
    gidx = onehot_idx(arb.grant);
    wait_cyc = dma_pkg::RSYNC_TO_READ_CYC;
    if (cur.state == dma_pkg::S_IDLE) begin
      next_cur.last_valid = 1'b0;               // switching only for an immediate successor
    end
    unique case (cur.state)
      dma_pkg::S_IDLE: begin
        if (|arb.grant) begin
          next_cur.chan = gidx;
          next_cur.mode = chan_mode[gidx];
          next_cur.mem = chan_mem[gidx];
          next_cur.frames = frame_count[gidx];
          next_cur.elems = elem_count[gidx];
          next_cur.elems_init = elem_count[gidx];
          next_cur.held = 6'h00;
          next_cur.in_burst = 6'h00;
          next_cur.wr = (chan_mode[gidx] == dma_pkg::MODE_WRITE);
          if (cur.last_valid && !cur.last_wr && next_cur.wr) begin
            // read to write across channels, extra when the successor is lower priority
            wait_cyc = dma_pkg::SW_RD_WR_CYC;
            if (cur.last_chan < gidx) begin
              wait_cyc = 6'(dma_pkg::SW_RD_WR_CYC + dma_pkg::HP_RD_LP_WR_CYC);
            end
          end else if (cur.last_valid) begin
            wait_cyc = dma_pkg::SW_WR_RD_CYC;
          end
          next_cur.cnt = 6'(wait_cyc - 6'h02);
          next_cur.state = dma_pkg::S_LEAD;
        end
      end
      dma_pkg::S_LEAD: begin
        if (cur.cnt == 6'h00) begin
          go = 1'b1;
          next_cur.flag[cur.chan] = 1'b0;       // cleared as the first access begins
        end else begin
          next_cur.cnt = 6'(cur.cnt - 6'h01);
        end
      end
      dma_pkg::S_SETUP: begin
        if (cur.cnt == 6'h00) begin
          next_cur.state = dma_pkg::S_STROBE;
          next_cur.cnt = 6'(elem_cyc(cur.mem) - 6'h01);
        end else begin
          next_cur.cnt = 6'(cur.cnt - 6'h01);
        end
      end
      dma_pkg::S_STROBE: begin
        if (cur.cnt != 6'h00) begin
          next_cur.cnt = 6'(cur.cnt - 6'h01);
        end else begin
          next_cur.in_burst = 6'(cur.in_burst + 6'h01);
          next_cur.cnt = 6'(elem_cyc(cur.mem) - 6'h01);
          if (!cur.wr) begin
            next_cur.elems = 8'(cur.elems - 8'h01);
            if (cur.mode == dma_pkg::MODE_SHARED) begin
              next_cur.held = 6'(cur.held + 6'h01);
            end
            // a read burst stops at the frame end, or at the shared burst size
            if (cur.elems == 8'h01 ||
                (cur.mode == dma_pkg::MODE_SHARED && next_cur.in_burst == burst_size(cur.mem))) begin
              fin = 1'b1;
            end
          end else if (cur.mode == dma_pkg::MODE_SHARED) begin
            next_cur.held = 6'(cur.held - 6'h01);
            fin = (cur.held == 6'h01);
          end else begin
            next_cur.elems = 8'(cur.elems - 8'h01);
            fin = (cur.elems == 8'h01);
          end
          if (fin && cur.mem != dma_pkg::MEM_INTERNAL) begin
            // hold chip enable so that it ends four cycles after the last strobe
            fin = 1'b0;
            next_cur.state = dma_pkg::S_HOLD;
            next_cur.cnt = 6'(dma_pkg::CE_HOLD_CYC - dma_pkg::ELEM_EXT_CYC - 6'h01);
          end
        end
      end
      dma_pkg::S_HOLD: begin
        if (cur.cnt == 6'h00) begin
          fin = 1'b1;
        end else begin
          next_cur.cnt = 6'(cur.cnt - 6'h01);
        end
      end
      dma_pkg::S_TURN, dma_pkg::S_GAP: begin
        if (cur.cnt == 6'h00) begin
          go = 1'b1;
        end else begin
          next_cur.cnt = 6'(cur.cnt - 6'h01);
        end
      end
    endcase

    // end of an access: turn around, next frame, or release the port
    if (fin) begin
      next_cur.in_burst = 6'h00;
      if (next_cur.mode == dma_pkg::MODE_SHARED && !next_cur.wr) begin
        // never read and write together: the held elements go out as a write burst
        next_cur.wr = 1'b1;
        next_cur.state = dma_pkg::S_TURN;
        next_cur.cnt = (next_cur.mem == dma_pkg::MEM_INTERNAL) ? 6'(dma_pkg::INT_RD_WR_CYC - 6'h01)
          : 6'(dma_pkg::SW_RD_WR_CYC + dma_pkg::EXTRA_RD_WR_CYC - 6'h01);
      end else if (next_cur.mode == dma_pkg::MODE_SHARED && next_cur.elems != 8'h00) begin
        next_cur.wr = 1'b0;
        next_cur.state = dma_pkg::S_TURN;
        next_cur.cnt = (next_cur.mem == dma_pkg::MEM_INTERNAL) ? 6'(dma_pkg::INT_WR_RD_CYC - 6'h01)
          : 6'(dma_pkg::SW_WR_RD_CYC + dma_pkg::EXTRA_WR_RD_CYC - 6'h01);
      end else if (next_cur.frames > 8'h01) begin
        // each frame is its own burst after a fixed gap
        next_cur.frames = 8'(next_cur.frames - 8'h01);
        next_cur.elems = next_cur.elems_init;
        next_cur.wr = (next_cur.mode == dma_pkg::MODE_WRITE);
        next_cur.state = dma_pkg::S_GAP;
        next_cur.cnt = 6'(dma_pkg::FRAME_GAP_CYC - 6'h01);
      end else begin
        next_cur.done[next_cur.chan] = 1'b1;
        next_cur.pend[next_cur.chan] = 1'b0;
        next_cur.last_valid = 1'b1;
        next_cur.last_wr = next_cur.wr;
        next_cur.last_chan = next_cur.chan;
        next_cur.state = dma_pkg::S_IDLE;
      end
    end

    // start an access: reads on external memory need a setup phase first
    if (go) begin
      if (next_cur.mem == dma_pkg::MEM_INTERNAL) begin
        next_cur.state = dma_pkg::S_STROBE;
        next_cur.cnt = 6'(dma_pkg::ELEM_INT_CYC - 6'h01);
      end else if (next_cur.wr) begin
        next_cur.state = dma_pkg::S_STROBE;
        next_cur.cnt = 6'(dma_pkg::ELEM_EXT_CYC - 6'h01);
      end else begin
        next_cur.state = dma_pkg::S_SETUP;
        next_cur.cnt = 6'(dma_pkg::CE_SETUP_CYC - 6'h01);
      end
    end

    // a start is taken only while the channel is not pending, so it never meets a clear of its flag
    for (int i = 0; i < dma_pkg::NCH; i++) begin
      if (start[i] && !cur.pend[i]) begin
        next_cur.pend[i] = 1'b1;
        next_cur.flag[i] = 1'b1;
      end
    end

    // port outputs registered from the next state; chip enable spans setup to hold
    next_cur.ce = (next_cur.state == dma_pkg::S_STROBE) ||
                  (next_cur.state == dma_pkg::S_SETUP) ||
                  (next_cur.state == dma_pkg::S_HOLD);
    next_cur.rd_stb = (next_cur.state == dma_pkg::S_STROBE) && !next_cur.wr &&
                      (next_cur.cnt == 6'(elem_cyc(next_cur.mem) - 6'h01));
    next_cur.wr_stb = (next_cur.state == dma_pkg::S_STROBE) && next_cur.wr &&
                      (next_cur.cnt == 6'(elem_cyc(next_cur.mem) - 6'h01));
  end

  // state register
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cur <= '{state: dma_pkg::S_IDLE, mode: dma_pkg::MODE_READ, mem: dma_pkg::MEM_INTERNAL, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs
  assign read_sync_pending_flag = cur.flag;
  assign chan_done = cur.done;
  assign busy = (cur.state != dma_pkg::S_IDLE);
  assign active_chan = cur.chan;
  assign mem_ce = cur.ce;
  assign mem_write = cur.wr;
  assign rd_strobe = cur.rd_stb;
  assign wr_strobe = cur.wr_stb;

  chk_no_read_write: assert property (@(posedge clock) disable iff (!nrst)
    mem_ce && mem_write |-> !rd_strobe)
    else $error("read strobe during a write access");

  chk_flag_after_start: assert property (@(posedge clock) disable iff (!nrst)
    start[0] && !cur.pend[0] |=> read_sync_pending_flag[0])
    else $error("sync flag not set one cycle after start");

  chk_flag_to_read: assert property (@(posedge clock) disable iff (!nrst)
    (cur.pend == 4'h1) && read_sync_pending_flag[0] && !$past(read_sync_pending_flag[0]) &&
    (cur.state == dma_pkg::S_IDLE) && !cur.last_valid && (chan_mode[0] != dma_pkg::MODE_WRITE) &&
    (chan_mem[0] != dma_pkg::MEM_INTERNAL) |-> ##11 $rose(mem_ce))
    else $error("first read not 11 cycles after sync flag");

  chk_setup_four: assert property (@(posedge clock) disable iff (!nrst)
    $rose(mem_ce) && !mem_write && (cur.mem != dma_pkg::MEM_INTERNAL) |-> !rd_strobe [*4] ##1 rd_strobe)
    else $error("first read data not 4 cycles after access start");

  chk_ce_hold_end: assert property (@(posedge clock) disable iff (!nrst)
    $fell(mem_ce) && (cur.mem != dma_pkg::MEM_INTERNAL) |-> $past(rd_strobe || wr_strobe, 4))
    else $error("chip enable did not end 4 cycles after last strobe");

  chk_frame_gap: assert property (@(posedge clock) disable iff (!nrst)
    (cur.state == dma_pkg::S_GAP) && ($past(cur.state) != dma_pkg::S_GAP) &&
    (cur.mem != dma_pkg::MEM_INTERNAL) |-> !mem_ce [*4] ##1 mem_ce)
    else $error("frame gap is not 4 cycles");

  chk_int_turn: assert property (@(posedge clock) disable iff (!nrst)
    (cur.state == dma_pkg::S_TURN) && ($past(cur.state) != dma_pkg::S_TURN) && cur.wr &&
    (cur.mem == dma_pkg::MEM_INTERNAL) |-> !wr_strobe [*8] ##1 wr_strobe)
    else $error("internal read to write turnaround not 8 cycles");

  chk_write_drains: assert property (@(posedge clock) disable iff (!nrst)
    (cur.state == dma_pkg::S_HOLD) && cur.wr && (cur.mode == dma_pkg::MODE_SHARED) |-> cur.held == 6'h00)
    else $error("write burst ended with elements still held");
endmodule : dma_shared_seq
`default_nettype wire

// File: dma_mem_model.sv
// passive model of the memory behind the port, counting strobes and illegal patterns
`timescale 1ns/1ps
`default_nettype none
module dma_mem_model (
  input  wire logic clock,      // core output clock
  input  wire logic nrst,       // async reset, active low
  input  wire logic mem_ce,     // chip enable from the sequencer
  input  wire logic mem_write,  // burst direction, 1 = write
  input  wire logic rd_strobe,  // read element strobe
  input  wire logic wr_strobe,  // write element strobe
  output var  int   rd_total,   // elements read since reset
  output var  int   wr_total,   // elements written since reset
  output var  int   faults      // strobes that a real memory would mishandle
);
  // a single-ported memory cannot take a read and a write together, nor a strobe while unselected
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_total <= 0;
      wr_total <= 0;
      faults   <= 0;
    end else begin
      rd_total <= rd_total + int'(rd_strobe === 1'b1);
      wr_total <= wr_total + int'(wr_strobe === 1'b1);
      if ((rd_strobe && wr_strobe) || ((rd_strobe || wr_strobe) && !mem_ce) || (wr_strobe && !mem_write)
          || (rd_strobe && mem_write)) begin
        faults <= faults + 1;
      end
    end
  end
endmodule : dma_mem_model
`default_nettype wire

// File: dma_shared_resource_timing_test.sv
// self-checking bench for the shared-resource dma sequencer
`timescale 1ns/1ps
`default_nettype none
module dma_shared_resource_timing_test;
  localparam int LEAD = int'(dma_pkg::RSYNC_TO_READ_CYC);  // flag set to first access
  localparam int SWITCH_ANY = 4;                            // write to any, or read to read, between channels
  typedef struct {logic wr; int n; int gap; int setup; int len; logic [1:0] ch; logic [3:0] done;} note_t;
  logic                  clock = 1'b0;  // 50 MHz
  logic                  nrst = 1'b0;   // held low at start
  logic [3:0]            start;
  dma_pkg::mode_t [3:0]  chan_mode;
  dma_pkg::mem_t  [3:0]  chan_mem;
  logic [3:0][7:0]       frame_count;
  logic [3:0][7:0]       elem_count;
  logic [3:0]            read_sync_pending_flag;
  logic [3:0]            chan_done;
  logic                  busy;
  logic [1:0]            active_chan;
  logic                  mem_ce;
  logic                  mem_write;
  logic                  rd_strobe;
  logic                  wr_strobe;
  int                    rd_total, wr_total, faults;
  int                    mismatches = 0;
  int                    num_checks = 0;
  int                    seed = 77;       // fixed seed for repeatable runs
  note_t                 notes[$];        // expected bursts, oldest first
  note_t                 cur;             // burst being watched
  int                    cyc = 0, cnt = 0, t_rise = 0, t_first = 0, n_str = 0;
  logic                  prev_ce = 1'b0;
  logic [3:0]            prev_flag = 4'h0;

  // clock source, inverted each half period
  always #10 clock = ~clock;

  dma_shared_seq dut (.clock(clock), .nrst(nrst), .start(start), .chan_mode(chan_mode), .chan_mem(chan_mem),
    .frame_count(frame_count), .elem_count(elem_count), .read_sync_pending_flag(read_sync_pending_flag),
    .chan_done(chan_done), .busy(busy), .active_chan(active_chan), .mem_ce(mem_ce), .mem_write(mem_write),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe));
  dma_mem_model mem (.clock(clock), .nrst(nrst), .mem_ce(mem_ce), .mem_write(mem_write), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .rd_total(rd_total), .wr_total(wr_total), .faults(faults));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // expected shape of one burst; internal memory enables only during its strobes
  function automatic note_t mk(logic wr, int n, int gap, logic ext, logic [1:0] ch, logic [3:0] done);
    note_t r;
    r.wr = wr;
    r.n = n;
    r.gap = gap;
    r.ch = ch;
    r.done = done;
    r.setup = (ext && !wr) ? int'(dma_pkg::CE_SETUP_CYC) : 0;
    r.len = ext ? r.setup + int'(dma_pkg::ELEM_EXT_CYC) * (n - 1) + int'(dma_pkg::CE_HOLD_CYC) : n;
    return r;
  endfunction : mk

  task automatic cfg(input int ch, input dma_pkg::mode_t m, input dma_pkg::mem_t k, input int f, input int e);
    @(posedge clock);
    chan_mode[ch] <= m;
    chan_mem[ch] <= k;
    frame_count[ch] <= 8'(f);
    elem_count[ch] <= 8'(e);
  endtask : cfg

  task automatic fire(input logic [3:0] mask);
    @(posedge clock);
    start <= mask;
    @(posedge clock);
    start <= 4'h0;
    @(negedge clock);
    check("flag_set", read_sync_pending_flag & mask, mask);
  endtask : fire

  // bounded wait until every noted burst has run and the port is idle again
  task automatic settle(input string name);
    int i;
    i = 0;
    while ((busy !== 1'b0 || notes.size() != 0) && i < 3000) begin
      @(negedge clock);
      i++;
    end
    if (i >= 3000) check("settle_timeout", 1, 0);
    repeat (5) @(posedge clock);
    $display("test %s done", name);
  endtask : settle

  // alternating read and write bursts of one channel on one memory
  task automatic shared(input int ch, input dma_pkg::mem_t k, input int e, input int bsz, input string name);
    int rem, r, g, rd0, wr0;
    logic ext;
    ext = (k != dma_pkg::MEM_INTERNAL);
    rem = e;
    g = LEAD;
    rd0 = rd_total;
    wr0 = wr_total;
    while (rem > 0) begin
      r = (rem < bsz) ? rem : bsz;
      rem -= r;
      notes.push_back(mk(1'b0, r, g, ext, 2'(ch), 4'h0));
      g = ext ? int'(dma_pkg::SW_RD_WR_CYC + dma_pkg::EXTRA_RD_WR_CYC) : int'(dma_pkg::INT_RD_WR_CYC);
      notes.push_back(mk(1'b1, r, g, ext, 2'(ch), (rem == 0) ? 4'(1 << ch) : 4'h0));
      g = ext ? int'(dma_pkg::SW_WR_RD_CYC + dma_pkg::EXTRA_WR_RD_CYC) : int'(dma_pkg::INT_WR_RD_CYC);
    end
    cfg(ch, dma_pkg::MODE_SHARED, k, 1, e);
    fire(4'(1 << ch));
    settle(name);
    check("held_drained", wr_total - wr0, rd_total - rd0);
  endtask : shared

  // watcher: measures each chip-enable window and compares it with the oldest note
  always @(negedge clock) begin
    cyc++;
    if (!nrst) begin
      cnt = 0;
      prev_ce = 1'b0;
      prev_flag = 4'h0;
    end else begin
      if ((read_sync_pending_flag & ~prev_flag) != 4'h0 && busy === 1'b0) cnt = 0;
      if (mem_ce === 1'b1 && !prev_ce) begin
        t_rise = cyc;
        n_str = 0;
        t_first = -1;
        if (notes.size() == 0) check("spare_burst", 1, 0);
        else begin
          cur = notes.pop_front();
          check("gap", cnt, cur.gap);
          check("owner", 32'(active_chan), 32'(cur.ch));
          check("direction", 32'(mem_write), 32'(cur.wr));
          check("flag_clear", 32'(read_sync_pending_flag[active_chan]), 0);
        end
      end
      if (mem_ce === 1'b1 && (rd_strobe === 1'b1 || wr_strobe === 1'b1)) begin
        if (t_first < 0) t_first = cyc - t_rise;
        n_str++;
      end
      if (mem_ce === 1'b0 && prev_ce) begin
        check("elements", n_str, cur.n);
        check("setup", t_first, cur.setup);
        check("ce_length", cyc - t_rise, cur.len);
        check("done", 32'(chan_done), 32'(cur.done));
        cnt = 0;
      end
      if (mem_ce !== 1'b1) cnt++;
      prev_ce = (mem_ce === 1'b1);
      prev_flag = read_sync_pending_flag;
    end
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    close_out();
  end

  // main sequence
  initial begin
    int e, i;
    start = 4'h0;
    for (i = 0; i < 4; i++) begin
      chan_mode[i] = dma_pkg::MODE_READ;
      chan_mem[i] = dma_pkg::MEM_INTERNAL;
      frame_count[i] = 8'h01;
      elem_count[i] = 8'h01;
    end
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    // two frames of random length, each its own burst
    e = 1 + ($unsigned($random(seed)) % 6);
    cfg(0, dma_pkg::MODE_READ, dma_pkg::MEM_SYNC_BURST, 2, e);
    notes.push_back(mk(1'b0, e, LEAD, 1'b1, 2'h0, 4'h0));
    notes.push_back(mk(1'b0, e, int'(dma_pkg::FRAME_GAP_CYC), 1'b1, 2'h0, 4'h1));
    fire(4'h1);
    settle("frames");
    // single write burst
    cfg(2, dma_pkg::MODE_WRITE, dma_pkg::MEM_SYNC_BURST, 1, 3);
    notes.push_back(mk(1'b1, 3, LEAD, 1'b1, 2'h2, 4'h4));
    fire(4'h4);
    settle("write");
    // frame sizes kept at whole bursts and at a remainder
    shared(1, dma_pkg::MEM_INTERNAL, 10, int'(dma_pkg::BURST_FAST), "shared_internal");
    shared(3, dma_pkg::MEM_DYNAMIC, 8, int'(dma_pkg::BURST_DYNAMIC), "shared_dynamic");
    // slow memory gathers a long burst before the writes start
    shared(2, dma_pkg::MEM_ASYNC, 40, int'(dma_pkg::BURST_ASYNC), "shared_async");
    // a lower channel started mid-transfer waits, then pays the read to write penalty
    cfg(0, dma_pkg::MODE_READ, dma_pkg::MEM_SYNC_BURST, 1, 2);
    cfg(1, dma_pkg::MODE_WRITE, dma_pkg::MEM_SYNC_BURST, 1, 2);
    notes.push_back(mk(1'b0, 2, LEAD, 1'b1, 2'h0, 4'h1));
    notes.push_back(mk(1'b1, 2, int'(dma_pkg::SW_RD_WR_CYC + dma_pkg::HP_RD_LP_WR_CYC), 1'b1, 2'h1, 4'h2));
    fire(4'h1);
    i = 0;
    while (mem_ce !== 1'b1 && i < 100) begin
      @(negedge clock);
      i++;
    end
    fire(4'h2);
    settle("queued_lower");
    // a writer outranks a reader started on the same edge
    cfg(0, dma_pkg::MODE_READ, dma_pkg::MEM_SYNC_BURST, 1, 1);
    cfg(2, dma_pkg::MODE_WRITE, dma_pkg::MEM_SYNC_BURST, 1, 1);
    notes.push_back(mk(1'b1, 1, LEAD, 1'b1, 2'h2, 4'h4));
    notes.push_back(mk(1'b0, 1, SWITCH_ANY, 1'b1, 2'h0, 4'h1));
    fire(4'h5);
    settle("write_first");
    // two readers together: lowest index first
    cfg(1, dma_pkg::MODE_READ, dma_pkg::MEM_SYNC_BURST, 1, 1);
    cfg(3, dma_pkg::MODE_READ, dma_pkg::MEM_SYNC_BURST, 1, 1);
    notes.push_back(mk(1'b0, 1, LEAD, 1'b1, 2'h1, 4'h2));
    notes.push_back(mk(1'b0, 1, SWITCH_ANY, 1'b1, 2'h3, 4'h8));
    fire(4'hA);
    settle("lowest_first");
    check("notes_left", notes.size(), 0);
    check("mem_faults", faults, 0);
    close_out();
  end
endmodule : dma_shared_resource_timing_test
`default_nettype wire
